// file: rtl/csw_half_carry.sv
// Half carry / borrow detector for byte and word ALU results
`timescale 1ns/100ps
module csw_half_carry (
  // ALU operation
  input wire csw_pkg::csw_alu_op_t alu_op,
  // Result
  output logic half_carry
);

  logic [4:0] nib_res;
  logic [8:0] byte_res;

  // ----------------------------------------------------------------
  // Carry out of the fourth (byte op) or eighth (word op) bit
  // ----------------------------------------------------------------
  always_comb begin
    if (alu_op.sub) begin
      nib_res = {1'b0, alu_op.opa[3:0]} - {1'b0, alu_op.opb[3:0]};
      byte_res = {1'b0, alu_op.opa[7:0]} - {1'b0, alu_op.opb[7:0]};
    end else begin
      nib_res = {1'b0, alu_op.opa[3:0]} + {1'b0, alu_op.opb[3:0]};
      byte_res = {1'b0, alu_op.opa[7:0]} + {1'b0, alu_op.opb[7:0]};
    end
    half_carry = alu_op.byte_op ? nib_res[csw_pkg::HC_BYTE_BIT] : byte_res[csw_pkg::HC_WORD_BIT];
  end

endmodule

// file: rtl/csw_pkg.sv
// Shared offsets, bit positions, reset values and carrier types of the CPU status word block
package csw_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_CORE_CTRL = 12'h004;
  localparam logic [11:0] OFF_INT_CTRL1 = 12'h008;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h00c;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h010;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_OVF_A = 15;
  localparam int unsigned BIT_OVF_B = 14;
  localparam int unsigned BIT_SAT_A = 13;
  localparam int unsigned BIT_SAT_B = 12;
  localparam int unsigned BIT_ANY_OVF = 11;
  localparam int unsigned BIT_ANY_SAT = 10;
  localparam int unsigned BIT_LOOP = 9;
  localparam int unsigned BIT_HALF_CARRY = 8;
  localparam int unsigned BIT_PRIO_HI = 7;
  localparam int unsigned BIT_PRIO_LO = 5;
  localparam int unsigned BIT_RA = 4;
  localparam int unsigned BIT_ALU_HI = 3;
  localparam int unsigned BIT_PRIO_TOP = 3;
  localparam int unsigned BIT_NEST_DIS = 15;
  localparam int unsigned HC_BYTE_BIT = 4;
  localparam int unsigned HC_WORD_BIT = 8;

  // Interrupt event bits
  localparam int unsigned EV_OVF_A = 0;
  localparam int unsigned EV_OVF_B = 1;
  localparam int unsigned EV_SAT_A = 2;
  localparam int unsigned EV_SAT_B = 3;
  localparam int unsigned EV_W = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic RST_PRIO_TOP = 1'b0;
  localparam logic RST_NEST_DIS = 1'b0;
  localparam logic [3:0] RST_IRQ = 4'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic upd_a;
    logic ovf_a;
    logic sat_a;
    logic upd_b;
    logic ovf_b;
    logic sat_b;
  } csw_dsp_ev_t;

  typedef struct packed {
    logic valid;
    logic byte_op;
    logic sub;
    logic [15:0] opa;
    logic [15:0] opb;
  } csw_alu_op_t;

  typedef struct packed {
    logic ovf_a;
    logic ovf_b;
    logic sat_a;
    logic sat_b;
    logic loop;
    logic half_carry;
    logic [2:0] prio_low;
    logic [3:0] alu_flags;
  } csw_status_t;

endpackage

// file: rtl/csw_status_regs.sv
// CPU status word with accumulator flags, priority bits and an APB register port
//
// What this block does
// - Bits 15 and 14 show overflow of accumulator A and B, else zero.
// - Bits 13 and 12 latch accumulator saturation and hold until cleared.
// - Bit 11 reads one when either accumulator overflowed, zero otherwise.
// - Bit 10 reads one when either sticky saturation flag is set.
// - Writes change bits 13 and 12 directly; writing zero to bit 10 clears both.
// - Bit 9 is read-only, one while a hardware loop runs.
// - Bit 8 holds carry or borrow from bit three (byte) or seven (word).
// - Priority level is the control top bit above status bits 7 to 5.
// - User interrupts are blocked while the top priority bit is one.
// - Bits 7 to 5 ignore writes while nesting disable is set.
`timescale 1ns/100ps
module csw_status_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // CPU datapath inputs
  input wire csw_pkg::csw_dsp_ev_t dsp_ev,
  input wire csw_pkg::csw_alu_op_t alu_op,
  input wire logic loop_active,
  // Status and priority outputs
  output logic [15:0] cpu_status_word,
  output logic [3:0] cpu_priority,
  output logic user_irq_block,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    csw_pkg::csw_status_t st;
    logic prio_top;
    logic nest_dis;
    logic [csw_pkg::EV_W-1:0] irq_mask;
    logic [31:0] prdata;
    logic pslverr;
  } csw_state_t;

  csw_state_t q, d;

  logic half_carry;
  logic [csw_pkg::EV_W-1:0] irq_stat;
  logic [csw_pkg::EV_W-1:0] ev_set;
  logic [csw_pkg::EV_W-1:0] ev_clr;
  logic [15:0] csw_word;
  logic setup_ph;
  logic wr_acc;
  logic wr_st_hi;
  logic wr_st_lo;
  logic wr_core;
  logic wr_int_ctrl;
  logic wr_irq_mask;
  logic wr_irq_stat;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
    addr_hit = (addr == off);
  endfunction

  function automatic logic addr_mapped(input logic [11:0] addr);
    addr_mapped = addr_hit(addr, csw_pkg::OFF_STATUS) || addr_hit(addr, csw_pkg::OFF_CORE_CTRL) ||
                  addr_hit(addr, csw_pkg::OFF_INT_CTRL1) || addr_hit(addr, csw_pkg::OFF_IRQ_STAT) ||
                  addr_hit(addr, csw_pkg::OFF_IRQ_MASK);
  endfunction

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite && addr_mapped(paddr);
  assign wr_st_hi = wr_acc && addr_hit(paddr, csw_pkg::OFF_STATUS) && pstrb[1];
  assign wr_st_lo = wr_acc && addr_hit(paddr, csw_pkg::OFF_STATUS) && pstrb[0];

  // Decoded once so the next-state logic and the checks agree on what a write hits
  assign wr_core = wr_acc && addr_hit(paddr, csw_pkg::OFF_CORE_CTRL) && pstrb[0];
  assign wr_int_ctrl = wr_acc && addr_hit(paddr, csw_pkg::OFF_INT_CTRL1) && pstrb[1];
  assign wr_irq_mask = wr_acc && addr_hit(paddr, csw_pkg::OFF_IRQ_MASK) && pstrb[0];
  assign wr_irq_stat = wr_acc && addr_hit(paddr, csw_pkg::OFF_IRQ_STAT) && pstrb[0];

  // ----------------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------------
  always_comb begin
    csw_word = csw_pkg::RST_STATUS;
    csw_word[csw_pkg::BIT_OVF_A] = q.st.ovf_a;
    csw_word[csw_pkg::BIT_OVF_B] = q.st.ovf_b;
    csw_word[csw_pkg::BIT_SAT_A] = q.st.sat_a;
    csw_word[csw_pkg::BIT_SAT_B] = q.st.sat_b;
    csw_word[csw_pkg::BIT_ANY_OVF] = q.st.ovf_a | q.st.ovf_b;
    csw_word[csw_pkg::BIT_ANY_SAT] = q.st.sat_a | q.st.sat_b;
    csw_word[csw_pkg::BIT_LOOP] = q.st.loop;
    csw_word[csw_pkg::BIT_HALF_CARRY] = q.st.half_carry;
    csw_word[csw_pkg::BIT_PRIO_HI:csw_pkg::BIT_PRIO_LO] = q.st.prio_low;
    csw_word[csw_pkg::BIT_RA] = 1'b0;
    csw_word[csw_pkg::BIT_ALU_HI:0] = q.st.alu_flags;
  end

  // ----------------------------------------------------------------
  // Half carry and interrupt flags
  // ----------------------------------------------------------------
  csw_half_carry u_half_carry (
    .alu_op(alu_op),
    .half_carry(half_carry)
  );

  // Events fire on a flag's rising edge only, so a held overflow raises one interrupt
  always_comb begin
    ev_set = '0;
    ev_set[csw_pkg::EV_OVF_A] = dsp_ev.upd_a && dsp_ev.ovf_a && !q.st.ovf_a;
    ev_set[csw_pkg::EV_OVF_B] = dsp_ev.upd_b && dsp_ev.ovf_b && !q.st.ovf_b;
    ev_set[csw_pkg::EV_SAT_A] = dsp_ev.sat_a && !q.st.sat_a;
    ev_set[csw_pkg::EV_SAT_B] = dsp_ev.sat_b && !q.st.sat_b;
    ev_clr = '0;
    if (wr_irq_stat) begin
      ev_clr = pwdata[csw_pkg::EV_W-1:0];
    end
  end

  csw_sticky_bits #(
    .W(csw_pkg::EV_W)
  ) u_irq_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set(ev_set),
    .clr(ev_clr),
    .flags(irq_stat)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // Software writes first; hardware updates below take priority
    if (wr_st_hi) begin
      d.st.ovf_a = pwdata[csw_pkg::BIT_OVF_A] & pwdata[csw_pkg::BIT_ANY_OVF];
      d.st.ovf_b = pwdata[csw_pkg::BIT_OVF_B] & pwdata[csw_pkg::BIT_ANY_OVF];
      d.st.sat_a = pwdata[csw_pkg::BIT_SAT_A] & pwdata[csw_pkg::BIT_ANY_SAT];
      d.st.sat_b = pwdata[csw_pkg::BIT_SAT_B] & pwdata[csw_pkg::BIT_ANY_SAT];
      d.st.half_carry = pwdata[csw_pkg::BIT_HALF_CARRY];
    end
    if (wr_st_lo) begin
      if (!q.nest_dis) begin
        d.st.prio_low = pwdata[csw_pkg::BIT_PRIO_HI:csw_pkg::BIT_PRIO_LO];
      end
      d.st.alu_flags = pwdata[csw_pkg::BIT_ALU_HI:0];
    end
    if (wr_core) begin
      d.prio_top = pwdata[csw_pkg::BIT_PRIO_TOP];
    end
    if (wr_int_ctrl) begin
      d.nest_dis = pwdata[csw_pkg::BIT_NEST_DIS];
    end
    if (wr_irq_mask) begin
      d.irq_mask = pwdata[csw_pkg::EV_W-1:0];
    end
    // Hardware wins over a software write in the same cycle, so no update is lost
    if (dsp_ev.upd_a) begin
      d.st.ovf_a = dsp_ev.ovf_a;
    end
    if (dsp_ev.upd_b) begin
      d.st.ovf_b = dsp_ev.ovf_b;
    end
    if (dsp_ev.sat_a) begin
      d.st.sat_a = 1'b1;
    end
    if (dsp_ev.sat_b) begin
      d.st.sat_b = 1'b1;
    end
    if (alu_op.valid) begin
      d.st.half_carry = half_carry;
    end
    d.st.loop = loop_active;
    // Read data is caught in the setup phase; a same-cycle flag update shows on the next read
    if (setup_ph) begin
      d.pslverr = !addr_mapped(paddr);
      d.prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (addr_hit(paddr, csw_pkg::OFF_STATUS)) begin
          d.prdata[15:0] = csw_word;
        end else if (addr_hit(paddr, csw_pkg::OFF_CORE_CTRL)) begin
          d.prdata[csw_pkg::BIT_PRIO_TOP] = q.prio_top;
        end else if (addr_hit(paddr, csw_pkg::OFF_INT_CTRL1)) begin
          d.prdata[csw_pkg::BIT_NEST_DIS] = q.nest_dis;
        end else if (addr_hit(paddr, csw_pkg::OFF_IRQ_STAT)) begin
          d.prdata[csw_pkg::EV_W-1:0] = irq_stat;
        end else if (addr_hit(paddr, csw_pkg::OFF_IRQ_MASK)) begin
          d.prdata[csw_pkg::EV_W-1:0] = q.irq_mask;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.prio_top <= csw_pkg::RST_PRIO_TOP;
      q.nest_dis <= csw_pkg::RST_NEST_DIS;
      q.irq_mask <= csw_pkg::RST_IRQ;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr && psel && penable;
  assign cpu_status_word = csw_word;
  assign cpu_priority = {q.prio_top, q.st.prio_low};
  assign user_irq_block = q.prio_top;
  assign irq = |(irq_stat & q.irq_mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_sat_clear_write;
    wr_st_hi && !pwdata[csw_pkg::BIT_ANY_SAT] && !dsp_ev.sat_a && !dsp_ev.sat_b;
  endsequence

  sequence s_status_read;
    setup_ph && !pwrite && addr_hit(paddr, csw_pkg::OFF_STATUS);
  endsequence

  sequence s_ovf_clear_write;
    wr_st_hi && !pwdata[csw_pkg::BIT_ANY_OVF] && !dsp_ev.upd_a && !dsp_ev.upd_b;
  endsequence

  sequence s_sat_direct_write;
    wr_st_hi && pwdata[csw_pkg::BIT_ANY_SAT] && !dsp_ev.sat_a && !dsp_ev.sat_b;
  endsequence

  sequence s_prio_open_write;
    wr_st_lo && !q.nest_dis;
  endsequence

  a_ovf_a_track: assert property (dsp_ev.upd_a |=> cpu_status_word[15] == $past(dsp_ev.ovf_a))
    else $error("overflow A flag does not follow accumulator A");

  a_ovf_b_track: assert property (dsp_ev.upd_b |=> cpu_status_word[14] == $past(dsp_ev.ovf_b))
    else $error("overflow B flag does not follow accumulator B");

  a_sat_a_sticky: assert property (dsp_ev.sat_a ##1 (!wr_st_hi)[*2] |=> cpu_status_word[13])
    else $error("saturation A flag did not stay set");

  a_sat_b_set: assert property (dsp_ev.sat_b |=> cpu_status_word[12] && cpu_status_word[10])
    else $error("saturation B flag not set");

  a_any_ovf: assert property (cpu_status_word[11] == (cpu_status_word[15] || cpu_status_word[14]))
    else $error("combined overflow flag wrong");

  a_any_sat: assert property (cpu_status_word[10] == (cpu_status_word[13] || cpu_status_word[12]))
    else $error("combined saturation flag wrong");

  a_sat_clear: assert property (s_sat_clear_write |=> !cpu_status_word[13] && !cpu_status_word[12])
    else $error("clearing combined saturation did not clear both flags");

  a_loop_flag: assert property (##1 cpu_status_word[9] == $past(loop_active))
    else $error("loop active flag does not follow the loop");

  a_half_carry: assert property (alu_op.valid && !wr_st_hi |=> cpu_status_word[8] == $past(half_carry))
    else $error("half carry flag not updated");

  a_prio_form: assert property (cpu_priority[3] == user_irq_block && cpu_priority[2:0] == cpu_status_word[7:5])
    else $error("priority level not formed from top bit and status bits");

  a_user_block: assert property (wr_core |=> user_irq_block == $past(pwdata[csw_pkg::BIT_PRIO_TOP]))
    else $error("user interrupts not blocked at top priority");

  a_prio_locked: assert property (wr_st_lo && q.nest_dis |=> $stable(cpu_status_word[7:5]))
    else $error("priority bits changed while nesting disabled");

  a_ra_zero: assert property (!cpu_status_word[4])
    else $error("read-only bit 4 is not zero");

  a_read_word: assert property (s_status_read |=> prdata[15:0] == $past(csw_word) && !pslverr)
    else $error("status read returned wrong data");

  a_irq_level: assert property (ev_set[csw_pkg::EV_SAT_A] && q.irq_mask[csw_pkg::EV_SAT_A] |=> irq)
    else $error("masked-in event did not raise the interrupt");

  a_any_ovf_set: assert property ((dsp_ev.upd_a && dsp_ev.ovf_a) || (dsp_ev.upd_b && dsp_ev.ovf_b) |=> cpu_status_word[11])
    else $error("combined overflow flag not set by an overflow");

  a_ovf_clear: assert property (s_ovf_clear_write |=> !cpu_status_word[15] && !cpu_status_word[14])
    else $error("clearing combined overflow did not clear both flags");

  a_sat_direct: assert property (s_sat_direct_write |=> cpu_status_word[13:12] == $past(pwdata[13:12]))
    else $error("direct write to saturation flags not taken");

  a_sat_a_hold: assert property (cpu_status_word[13] && !wr_st_hi |=> cpu_status_word[13])
    else $error("saturation A flag dropped without a write");

  a_sat_b_hold: assert property (cpu_status_word[12] && !wr_st_hi |=> cpu_status_word[12])
    else $error("saturation B flag dropped without a write");

  a_any_sat_set: assert property (dsp_ev.sat_a || dsp_ev.sat_b |=> cpu_status_word[10])
    else $error("combined saturation flag not set by saturation");

  a_prio_write: assert property (s_prio_open_write |=> cpu_status_word[7:5] == $past(pwdata[7:5]))
    else $error("priority bits not written while nesting enabled");

  a_half_keep: assert property (!alu_op.valid && !wr_st_hi |=> $stable(cpu_status_word[8]))
    else $error("half carry flag changed without an operation");

  a_loop_ro_write: assert property (wr_st_hi |=> cpu_status_word[9] == $past(loop_active))
    else $error("loop active flag taken from a software write");

  a_top_write: assert property (wr_core |=> cpu_priority[3] == $past(pwdata[csw_pkg::BIT_PRIO_TOP]))
    else $error("top priority bit not written");

  a_nest_write: assert property (wr_int_ctrl |=> q.nest_dis == $past(pwdata[csw_pkg::BIT_NEST_DIS]))
    else $error("nesting disable not written");

  a_mask_write: assert property (wr_irq_mask |=> q.irq_mask == $past(pwdata[csw_pkg::EV_W-1:0]))
    else $error("interrupt mask not written");

  a_irq_w1c: assert property (wr_irq_stat && pwdata[2] && !ev_set[2] |=> !irq_stat[2])
    else $error("interrupt status bit not cleared by writing one");

  a_slverr_map: assert property (psel && penable && !addr_mapped(paddr) |-> pslverr)
    else $error("unmapped access did not signal an error");

  a_read_unmapped: assert property (setup_ph && !pwrite && !addr_mapped(paddr) |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

endmodule

// file: rtl/csw_sticky_bits.sv
// Sticky event flags, set by hardware and cleared by writing ones
`timescale 1ns/100ps
module csw_sticky_bits #(
  parameter int unsigned W = csw_pkg::EV_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Set and clear
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Flags
  output logic [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } csw_sticky_state_t;

  csw_sticky_state_t q, d;

  if (W < 1 || W > 32) begin : g_bad_width
    $error("csw_sticky_bits: W must be 1 to 32");
  end

  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    d = q;
    d.flags = (q.flags & ~clr) | set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign flags = q.flags;

endmodule

// file: tb/csw_status_regs_tb.sv
// Self-checking testbench for the CPU status word block
`timescale 1ns/100ps
module csw_status_regs_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  csw_pkg::csw_dsp_ev_t dsp_ev;
  csw_pkg::csw_alu_op_t alu_op;
  logic loop_active;
  logic [15:0] cpu_status_word;
  logic [3:0] cpu_priority;
  logic user_irq_block;
  logic irq;
  int bad_count;
  int total_checks;
  logic [3:0] strb_use;

  csw_status_regs DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .dsp_ev(dsp_ev), .alu_op(alu_op), .loop_active(loop_active),
    .cpu_status_word(cpu_status_word), .cpu_priority(cpu_priority),
    .user_irq_block(user_irq_block), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the access phase is held until pready is seen high
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb_use;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 16) begin
        bad_count++;
        complete_run();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apb_write(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb_xfer(1'b1, a, d, rd, err);
  endtask

  task automatic read_check(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb_xfer(1'b0, a, 32'h0000_0000, rd, err);
    check(what, rd, exp);
  endtask

  task automatic dsp_pulse(input logic [5:0] bits);
    @(posedge pclk);
    dsp_ev <= csw_pkg::csw_dsp_ev_t'(bits);
    @(posedge pclk);
    dsp_ev <= '0;
  endtask

  task automatic word_check(input string what, input logic [15:0] exp);
    @(negedge pclk);
    check(what, 32'(cpu_status_word), 32'(exp));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    word_check("status after reset", 16'h0000);
    check("priority after reset", 32'(cpu_priority), 32'h0);
    check("irq after reset", 32'(irq), 32'h0);
    check("ready idle", 32'(pready), 32'h1);
    read_check("status reg reset", csw_pkg::OFF_STATUS, 32'h0);
    read_check("core ctrl reset", csw_pkg::OFF_CORE_CTRL, 32'h0);
    read_check("int ctrl reset", csw_pkg::OFF_INT_CTRL1, 32'h0);
    read_check("irq stat reset", csw_pkg::OFF_IRQ_STAT, 32'h0);
    read_check("irq mask reset", csw_pkg::OFF_IRQ_MASK, 32'h0);
  endtask

  task automatic test_overflow();
    dsp_pulse(6'b110000);
    word_check("ovf a set", 16'h8800);
    dsp_pulse(6'b000110);
    word_check("ovf b set", 16'hc800);
    dsp_pulse(6'b100000);
    word_check("ovf a cleared", 16'h4800);
    read_check("ovf b readback", csw_pkg::OFF_STATUS, 32'h0000_4800);
    apb_write(csw_pkg::OFF_STATUS, 32'h0000_4000);
    word_check("combined ovf clear", 16'h0000);
  endtask

  task automatic test_saturation();
    dsp_pulse(6'b001000);
    repeat (3) @(posedge pclk);
    word_check("sat a sticky", 16'h2400);
    dsp_pulse(6'b000001);
    word_check("sat b sticky", 16'h3400);
    apb_write(csw_pkg::OFF_STATUS, 32'h0000_3000);
    word_check("combined sat clear", 16'h0000);
    apb_write(csw_pkg::OFF_STATUS, 32'h0000_1400);
    word_check("sat b direct write", 16'h1400);
    apb_write(csw_pkg::OFF_STATUS, 32'h0000_0400);
    word_check("sat b direct clear", 16'h0000);
  endtask

  task automatic test_loop();
    @(posedge pclk);
    loop_active <= 1'b1;
    @(posedge pclk);
    word_check("loop flag on", 16'h0200);
    apb_write(csw_pkg::OFF_STATUS, 32'h0000_0000);
    word_check("loop flag write", 16'h0200);
    @(posedge pclk);
    loop_active <= 1'b0;
    @(posedge pclk);
    word_check("loop flag off", 16'h0000);
    apb_write(csw_pkg::OFF_STATUS, 32'h0000_0210);
    word_check("read-only bits", 16'h0000);
  endtask

  task automatic test_half_carry();
    logic [35:0] cases [7];
    cases = '{{1'b1, 1'b0, 16'h000f, 16'h0001, 2'b01}, {1'b1, 1'b0, 16'h0007, 16'h0001, 2'b00},
              {1'b0, 1'b0, 16'h00ff, 16'h0001, 2'b01}, {1'b0, 1'b0, 16'h000f, 16'h0001, 2'b00},
              {1'b1, 1'b1, 16'h0010, 16'h0001, 2'b01}, {1'b0, 1'b1, 16'h0100, 16'h0001, 2'b01},
              {1'b0, 1'b1, 16'h0010, 16'h0001, 2'b00}};
    foreach (cases[i]) begin
      @(posedge pclk);
      alu_op <= csw_pkg::csw_alu_op_t'({1'b1, cases[i][35:2]});
      @(posedge pclk);
      alu_op <= '0;
      word_check("half carry", {7'h00, cases[i][0], 8'h00});
    end
  endtask

  task automatic test_priority();
    apb_write(csw_pkg::OFF_STATUS, 32'h0000_00a0);
    @(negedge pclk);
    check("priority low", 32'(cpu_priority), 32'h5);
    apb_write(csw_pkg::OFF_CORE_CTRL, 32'h0000_0008);
    @(negedge pclk);
    check("priority top", 32'(cpu_priority), 32'hd);
    check("user irq block on", 32'(user_irq_block), 32'h1);
    apb_write(csw_pkg::OFF_INT_CTRL1, 32'h0000_8000);
    apb_write(csw_pkg::OFF_STATUS, 32'h0000_0000);
    word_check("priority locked", 16'h00a0);
    apb_write(csw_pkg::OFF_INT_CTRL1, 32'h0000_0000);
    apb_write(csw_pkg::OFF_STATUS, 32'h0000_0000);
    word_check("priority unlocked", 16'h0000);
    apb_write(csw_pkg::OFF_CORE_CTRL, 32'h0000_0000);
    @(negedge pclk);
    check("user irq block off", 32'(user_irq_block), 32'h0);
    strb_use = 4'h2;
    apb_write(csw_pkg::OFF_STATUS, 32'h0000_00e0);
    word_check("low lane not written", 16'h0000);
    strb_use = 4'hf;
  endtask

  task automatic test_irq();
    logic [5:0] evs [4];
    logic [31:0] rd;
    logic err;
    evs = '{6'b110000, 6'b000110, 6'b001000, 6'b000001};
    foreach (evs[i]) begin
      apb_write(csw_pkg::OFF_STATUS, 32'h0000_0000);
      apb_write(csw_pkg::OFF_IRQ_MASK, 32'h0000_0000);
      apb_write(csw_pkg::OFF_IRQ_STAT, 32'h0000_000f);
      dsp_pulse(evs[i]);
      @(negedge pclk);
      check("irq masked", 32'(irq), 32'h0);
      read_check("irq stat event", csw_pkg::OFF_IRQ_STAT, 32'h1 << i);
      apb_write(csw_pkg::OFF_IRQ_MASK, 32'h1 << i);
      read_check("irq mask readback", csw_pkg::OFF_IRQ_MASK, 32'h1 << i);
      @(negedge pclk);
      check("irq unmasked", 32'(irq), 32'h1);
      apb_write(csw_pkg::OFF_IRQ_STAT, 32'h1 << i);
      @(negedge pclk);
      check("irq cleared", 32'(irq), 32'h0);
    end
    apb_write(csw_pkg::OFF_IRQ_MASK, 32'h0000_000f);
    dsp_pulse(6'b001000);
    @(negedge pclk);
    check("irq unmasked event", 32'(irq), 32'h1);
    apb_write(csw_pkg::OFF_IRQ_STAT, 32'h0000_000f);
    @(negedge pclk);
    check("irq all cleared", 32'(irq), 32'h0);
    apb_xfer(1'b0, 12'h020, 32'h0000_0000, rd, err);
    check("unmapped data", rd, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    strb_use = 4'hf;
    dsp_ev = '0;
    alu_op = '0;
    loop_active = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_overflow();
    test_saturation();
    test_loop();
    test_half_carry();
    test_priority();
    test_irq();
    complete_run();
  end
endmodule
